// ---- lpmr_ctrl_model.sv ----
`timescale 1ns/1ps
module lpmr_ctrl_model (
    // Clock
    input  wire logic                ref_clk,
    // Request from the bench
    input  wire lpmr_pkg::lpmr_cmd_t req,
    // Command bus toward the device
    input  wire logic                cmd_ready,
    output lpmr_pkg::lpmr_cmd_t      cmd,
    output logic                     taken
);
    lpmr_pkg::lpmr_cmd_t cmd_reg   = '0;
    logic                taken_reg = 1'b0;
    assign cmd   = cmd_reg;
    assign taken = taken_reg;
    // Note acceptance at the sampling edge
    always @(posedge ref_clk)
        taken_reg <= cmd_reg.valid && cmd_ready;
    always @(negedge ref_clk)
    begin
        if (taken_reg)
            cmd_reg <= {1'b0, ~cmd_reg[16:0]};  // Released fields scrambled
        else if (!cmd_reg.valid && req.valid)
            cmd_reg <= req;
    end
endmodule : lpmr_ctrl_model

// ---- lpmr_mode_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Read command returns a register, write command updates one.
// - Read-only answers reads, write-only takes writes.
// - Decode 00h-0Ah, 10h/11h and 3Fh to their documented functions.
// - Calibration pattern A at 20h and pattern B at 28h, read-only.
// - Reserved bits of read data return zero.
// - Reads of write-only or reserved registers toggle strobe, data undefined.
// - Writes to read-only registers change nothing.
// - Bit 0 shows auto-init running; bit 1 shows memory kind.
// - Self-test field bits 4:3 updates when initialization calibration write completes.
// - Pin tied to core supply reports self-test result 01.
// - Result 01 or 10 selects factory trim, later calibrations ignored.
// - Result 11 means a resistor was detected on the pin.
// - After reset command, auto-init bit clears within the longest duration.
module lpmr_mode_regs #(
    parameter int         BURST_BEATS     = lpmr_pkg::BURST_BEATS_DEF,
    parameter logic       SELFTEST_EXISTS = 1'b1,
    parameter logic       MEMORY_KIND     = 1'b0,
    parameter logic [7:0] MAKER_CODE      = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REVISION_ONE    = 8'h01,  // Arbitrary value
    parameter logic [7:0] REVISION_TWO    = 8'h00,  // Arbitrary value
    parameter logic [7:0] GEOMETRY        = 8'h00,
    parameter logic [7:0] CAL_PATTERN_A   = 8'h00,
    parameter logic [7:0] CAL_PATTERN_B   = 8'h00
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // Mode register command
    input  wire lpmr_pkg::lpmr_cmd_t      cmd,
    output logic                          cmd_ready,
    // Read answer
    output lpmr_pkg::lpmr_rsp_t           rsp,
    // Impedance pin sense
    input  wire logic                     zq_tied_vdd,
    input  wire logic                     zq_short_gnd,
    input  wire logic                     zq_resistor_seen,
    // Refresh status inputs
    input  wire logic                     temp_update_flag,
    input  wire logic [2:0]               refresh_rate,
    // Device side effects
    output lpmr_pkg::lpmr_settings_t      settings,
    output logic                          auto_init_status,
    output logic                          factory_trim,
    output logic                          imp_cal_start
);

    // Parameter check
    if (BURST_BEATS < 1 || BURST_BEATS > 255)
    begin : g_bad_beats
        $error("BURST_BEATS must lie in 1..255");
    end

    // Init counter must hold the longest auto-init count
    if (lpmr_pkg::AUTO_INIT_CYC > 256)
    begin : g_bad_init
        $error("AUTO_INIT_CYC exceeds the 8-bit init counter");
    end

    // Settings carrier must match the write-only slot count
    if ($bits(lpmr_pkg::lpmr_settings_t) != 8 * lpmr_pkg::WO_COUNT)
    begin : g_bad_slots
        $error("Settings carrier width differs from the slot count");
    end

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_BURST = 2'b10
    } lpmr_state_t;

    localparam int WO_COUNT_L = lpmr_pkg::WO_COUNT;

    lpmr_state_t  state_reg;
    lpmr_state_t  state_next;
    logic [7:0]   beat_reg;
    logic         strobe_reg;
    logic         undef_reg;
    logic [7:0]   data_reg;
    logic [7:0]   init_cnt_reg;
    logic         init_busy_reg;
    logic [1:0]   selftest_reg;
    logic [1:0]   selftest_next;
    logic         trim_reg;
    logic         cal_start_reg;
    logic         rd_take;
    logic         wr_take;
    logic         soft_reset;
    logic         cal_write;
    logic         cal_init_write;
    logic [8*WO_COUNT_L-1:0] wo_vals;
    logic [7:0]   rd_value;
    logic         rd_defined;
    logic [7:0]   dev_info;
    logic [7:0]   refresh_status;

    // Command acceptance
    assign cmd_ready = (state_reg == ST_IDLE);
    assign rd_take   = cmd.valid && cmd_ready && !cmd.write;
    assign wr_take   = cmd.valid && cmd_ready && cmd.write;

    assign soft_reset     = wr_take && (cmd.addr == lpmr_pkg::MA_SOFT_RESET);
    assign cal_write      = wr_take && (cmd.addr == lpmr_pkg::MA_IMP_CAL_CMD);
    assign cal_init_write = cal_write && (cmd.wdata == lpmr_pkg::IMP_CAL_INIT_CODE);

    // Write-only register slots
    // write stores
    for (genvar i = 0; i < WO_COUNT_L; i++)
    begin : g_wo
        lpmr_wreg #(
            .ADDR      (lpmr_pkg::WO_ADDRS[8*i +: 8]),
            .RESET_VAL (lpmr_pkg::WO_RESETS[8*i +: 8])
        ) u_wreg (
            .ref_clk (ref_clk),
            .rst     (rst),
            .clear   (soft_reset),
            .wr_en   (wr_take),
            .wr_addr (cmd.addr),
            .wr_data (cmd.wdata),
            .value   (wo_vals[8*i +: 8]),
            .hit     ()
        );
    end

    // Settings view for the rest of the device
    assign settings = lpmr_pkg::lpmr_settings_t'(wo_vals);

    // Device information assembly
    // reserved zero
    always_comb
    begin
        dev_info = 8'h00;
        dev_info[lpmr_pkg::DI_AUTO_INIT_BIT] = init_busy_reg;
        dev_info[lpmr_pkg::DI_KIND_BIT]      = MEMORY_KIND;
        dev_info[lpmr_pkg::DI_INVALID_BIT]   = 1'b0;
        dev_info[lpmr_pkg::DI_SELFTEST_LSB +: 2] = selftest_reg;
    end

    // Refresh status assembly
    // reserved zero
    always_comb
    begin
        refresh_status = 8'h00;
        refresh_status[lpmr_pkg::RS_TEMP_FLAG_BIT] = temp_update_flag;
        refresh_status[2:0] = refresh_rate;
    end

    // Read decode
    // read-only reads
    always_comb
    begin
        rd_value   = 8'h00;
        rd_defined = 1'b1;
        case (cmd.addr)
            lpmr_pkg::MA_DEVICE_INFO:   rd_value = dev_info;
            lpmr_pkg::MA_REFRESH_STAT:  rd_value = refresh_status;
            lpmr_pkg::MA_MAKER_CODE:    rd_value = MAKER_CODE;
            lpmr_pkg::MA_REVISION_ONE:  rd_value = REVISION_ONE;
            lpmr_pkg::MA_REVISION_TWO:  rd_value = REVISION_TWO;
            lpmr_pkg::MA_GEOMETRY:      rd_value = GEOMETRY;
            lpmr_pkg::MA_CAL_PATTERN_A: rd_value = CAL_PATTERN_A;
            lpmr_pkg::MA_CAL_PATTERN_B: rd_value = CAL_PATTERN_B;
            default:                    rd_defined = 1'b0;
        endcase
    end

    // Burst state sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (rd_take)
                begin
                    state_next = ST_BURST;
                end
            end
            ST_BURST:
            begin
                if (beat_reg == 8'(BURST_BEATS - 1))
                begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Beat counter and strobe
    // strobe toggles every beat
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            beat_reg   <= 8'h00;
            strobe_reg <= 1'b0;
        end
        else if (rd_take)
        begin
            beat_reg   <= 8'h00;
            strobe_reg <= 1'b1;
        end
        else if (state_reg == ST_BURST)
        begin
            beat_reg   <= beat_reg + 8'h01;
            strobe_reg <= (state_next == ST_BURST) ? ~strobe_reg : 1'b0;
        end
    end

    // Read data capture, held through the burst
    // read returns contents
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            data_reg  <= 8'h00;
            undef_reg <= 1'b0;
        end
        else if (rd_take)
        begin
            data_reg  <= rd_value;
            undef_reg <= ~rd_defined;
        end
    end

    assign rsp.valid     = (state_reg == ST_BURST);
    assign rsp.strobe    = strobe_reg;
    assign rsp.undefined = undef_reg;
    assign rsp.data      = data_reg;

    // Auto-initialization timer
    // bounded auto-init
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            init_busy_reg <= 1'b1;
            init_cnt_reg  <= 8'h00;
        end
        else if (soft_reset)
        begin
            init_busy_reg <= 1'b1;
            init_cnt_reg  <= 8'h00;
        end
        else if (init_busy_reg)
        begin
            init_cnt_reg <= init_cnt_reg + 8'h01;
            if (init_cnt_reg == 8'(lpmr_pkg::AUTO_INIT_CYC - 1))
            begin
                init_busy_reg <= 1'b0;
            end
        end
    end

    assign auto_init_status = init_busy_reg;

    // Self-test outcome from the pin sense
    // tied pin
    always_comb
    begin
        if (zq_tied_vdd)
        begin
            selftest_next = lpmr_pkg::ST_TIED_VDD;
        end
        else if (zq_short_gnd)
        begin
            selftest_next = lpmr_pkg::ST_SHORT_GND;
        end
        else if (zq_resistor_seen)
        begin
            selftest_next = lpmr_pkg::ST_RESISTOR;
        end
        else
        begin
            selftest_next = lpmr_pkg::ST_TIED_VDD;
        end
    end

    // Self-test result and trim latch
    // update on init calibration
    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_reset)
        begin
            selftest_reg <= lpmr_pkg::ST_NOT_RUN;
            trim_reg     <= 1'b0;
        end
        else if (cal_init_write && SELFTEST_EXISTS && !trim_reg)
        begin
            selftest_reg <= selftest_next;
            trim_reg     <= (selftest_next == lpmr_pkg::ST_TIED_VDD)
                         || (selftest_next == lpmr_pkg::ST_SHORT_GND);
        end
    end

    assign factory_trim = trim_reg;

    // Calibration start pulse
    // ignore calibration
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cal_start_reg <= 1'b0;
        end
        else if (cal_init_write && SELFTEST_EXISTS && !trim_reg)
        begin
            cal_start_reg <= (selftest_next == lpmr_pkg::ST_RESISTOR);
        end
        else
        begin
            cal_start_reg <= cal_write && !trim_reg;
        end
    end

    assign imp_cal_start = cal_start_reg;

    // Writes to read-only and reserved addresses fall through every decode above
    // read-only writes ignored

endmodule : lpmr_mode_regs

// ---- lpmr_mode_regs_asserts.sv ----
`timescale 1ns/1ps
module lpmr_mode_regs_asserts #(
    parameter int BURST_BEATS = 4
) (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rst,
    // Command and answer
    input wire lpmr_pkg::lpmr_cmd_t      cmd,
    input wire logic                     cmd_ready,
    input wire lpmr_pkg::lpmr_rsp_t      rsp,
    // Side effects
    input wire lpmr_pkg::lpmr_settings_t settings,
    input wire logic                     auto_init_status,
    input wire logic                     factory_trim,
    input wire logic                     imp_cal_start
);
    localparam int AI_MAX = 100;
    localparam int AI_TAIL = AI_MAX - 7;
    logic       take_rd;
    logic       take_wr;
    logic [7:0] rd_addr;
    int         beats;
    // Taken commands
    assign take_rd = cmd.valid && cmd_ready && !cmd.write;
    assign take_wr = cmd.valid && cmd_ready && cmd.write;
    // Readable places
    function automatic logic readable(input logic [7:0] a);
        return a == 8'h00 || (a >= 8'h04 && a <= 8'h08) || a == 8'h20 || a == 8'h28;
    endfunction : readable
    // Writable places
    function automatic logic writable(input logic [7:0] a);
        return (a >= 8'h01 && a <= 8'h03) || a == 8'h09 || a == 8'h0a || a == 8'h10 || a == 8'h11 || a == 8'h3f;
    endfunction : writable
    // Address of the read in flight
    always_ff @(posedge ref_clk)
    begin
        if (take_rd)
            rd_addr <= cmd.addr;
    end
    // Beats of the current burst
    always_ff @(posedge ref_clk)
    begin
        if (rst || !rsp.valid)
            beats <= 0;
        else
            beats <= beats + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_take_reset;
        take_wr && cmd.addr == 8'h3f;
    endsequence
    sequence s_init_run;
        auto_init_status [*8] ##[1:AI_TAIL] !auto_init_status;
    endsequence
    property p_burst_start;
        take_rd |=> rsp.valid && rsp.strobe && !cmd_ready;
    endproperty
    property p_strobe;
        rsp.valid && $past(rsp.valid) |-> rsp.strobe != $past(rsp.strobe);
    endproperty
    property p_burst_len;
        $fell(rsp.valid) |-> beats == BURST_BEATS && cmd_ready;
    endproperty
    property p_undef;
        rsp.valid |-> rsp.undefined == !readable(rd_addr);
    endproperty
    property p_rsv_zero;
        rsp.valid |-> (rd_addr != 8'h00 || (rsp.data[7:5] == 3'h0 && !rsp.data[2]))
            && (rd_addr != 8'h04 || rsp.data[6:3] == 4'h0);
    endproperty
    property p_init_bit;
        rsp.valid && !$past(rsp.valid) && rd_addr == 8'h00 |-> rsp.data[0] == $past(auto_init_status);
    endproperty
    property p_reset_cmd;
        s_take_reset |=> s_init_run;
    endproperty
    property p_wo_write;
        take_wr && cmd.addr == 8'h01 |=> settings.burst_setup == $past(cmd.wdata);
    endproperty
    property p_ro_write;
        take_wr && !writable(cmd.addr) |=> $stable(settings) && !imp_cal_start;
    endproperty
    property p_trim;
        factory_trim && take_wr && cmd.addr == 8'h0a |=> !imp_cal_start;
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("read burst did not start");
    a_strobe: assert property (p_strobe) else $error("strobe did not toggle");
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
    a_undef: assert property (p_undef) else $error("undefined flag wrong");
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read bits not zero");
    a_init_bit: assert property (p_init_bit) else $error("init bit differs from status");
    a_reset_cmd: assert property (p_reset_cmd) else $error("auto init timing wrong");
    a_wo_write: assert property (p_wo_write) else $error("write not stored");
    a_ro_write: assert property (p_ro_write) else $error("ignored write had effect");
    a_trim: assert property (p_trim) else $error("calibration ran under trim");
endmodule : lpmr_mode_regs_asserts
bind lpmr_mode_regs lpmr_mode_regs_asserts #(.BURST_BEATS(BURST_BEATS)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .settings(settings), .auto_init_status(auto_init_status),
    .factory_trim(factory_trim), .imp_cal_start(imp_cal_start));

// ---- lpmr_mode_regs_tb.sv ----
`timescale 1ns/1ps
module lpmr_mode_regs_tb;
    logic                     ref_clk;
    logic                     rst;
    lpmr_pkg::lpmr_cmd_t      req;
    lpmr_pkg::lpmr_cmd_t      cmd;
    lpmr_pkg::lpmr_rsp_t      rsp;
    lpmr_pkg::lpmr_settings_t settings;
    logic                     cmd_ready;
    logic                     taken;
    logic [2:0]               zq;
    logic                     tflag;
    logic [2:0]               rate;
    logic                     ai;
    logic                     trim;
    logic                     cal;
    logic [31:0]              seed;
    logic [55:0]              exp_set;
    logic [9:0]               notes[$];
    logic [9:0]               note;
    logic                     seen = 1'b0;
    logic [7:0]               d;
    int                       error_cnt;
    int                       comparisons;
    int                       pulses;
    int                       p0;
    // Readable addresses and values, unreadable and ignored-write addresses
    localparam logic [63:0]   RO_ADDRS = 64'h0004050607082028;
    localparam logic [63:0]   RO_VALS  = 64'h00005a01000055aa;
    localparam logic [63:0]   BAD_RD   = 64'h0b12304021807fff;
    localparam logic [31:0]   BAD_WR   = 32'h21bf807f;
    // Device and far-side controller
    lpmr_mode_regs #(.CAL_PATTERN_A(8'h55), .CAL_PATTERN_B(8'haa)) dut_u (.ref_clk(ref_clk), .rst(rst),
        .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .zq_tied_vdd(zq[2]), .zq_short_gnd(zq[1]),
        .zq_resistor_seen(zq[0]), .temp_update_flag(tflag), .refresh_rate(rate), .settings(settings),
        .auto_init_status(ai), .factory_trim(trim), .imp_cal_start(cal));
    lpmr_ctrl_model ctl_u (.ref_clk(ref_clk), .req(req), .cmd_ready(cmd_ready), .cmd(cmd), .taken(taken));
    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input string name, input logic [55:0] e, input logic [55:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", name, e, g);
        end
    endtask : chk
    task automatic final_report;
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        @(negedge ref_clk);
        req <= {1'b1, w, a, v};
        n = 0;
        while (!taken && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        req.valid <= 1'b0;
        if (!taken)
        begin
            error_cnt++;
            final_report();
        end
    endtask : issue
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic c);
        notes.push_back({c, !c, e});
        issue(1'b0, a, 8'h00);
    endtask : rd
    // Read answers against the oldest note; calibration pulses
    always @(negedge ref_clk)
    begin
        seen <= rsp.valid;
        if (cal === 1'b1)
            pulses++;
        if (rsp.valid === 1'b1 && !seen)
        begin
            note = notes.pop_front();
            if (note[9])
                chk("read data", note[8:0], {rsp.undefined, rsp.data});
            else
                chk("read undefined", note[8], rsp.undefined);
        end
    end
    // Main sequence
    initial
    begin
        req = '0;
        rst = 1'b1;
        zq = 3'h0;
        tflag = 1'b0;
        rate = 3'h0;
        seed = 32'd39425;
        repeat (3) @(negedge ref_clk);
        rst <= 1'b0;
        rd(8'h00, 8'h01, 1'b1);
        repeat (110) @(negedge ref_clk);
        rd(8'h00, 8'h00, 1'b1);
        exp_set = lpmr_pkg::WO_RESETS;
        p0 = pulses;
        for (int i = 0; i < lpmr_pkg::WO_COUNT; i++)
        begin
            seed = xs(seed);
            d = seed[7:0] & ((i == 1 || i == 2) ? 8'h0f : 8'h7f);
            exp_set[i*8+:8] = d;
            issue(1'b1, lpmr_pkg::WO_ADDRS[i*8+:8], d);
            rd(lpmr_pkg::WO_ADDRS[i*8+:8], 8'h00, 1'b0);
        end
        chk("settings", exp_set, settings);
        chk("plain cal pulses", 1, pulses - p0);
        seed = xs(seed);
        tflag <= seed[8];
        rate <= seed[2:0];
        for (int i = 0; i < 8; i++)
        begin
            d = RO_VALS[(7 - i) * 8 +: 8];
            if (i == 1)
                d = {seed[8], 4'h0, seed[2:0]};
            rd(RO_ADDRS[(7 - i) * 8 +: 8], d, 1'b1);
            issue(1'b1, RO_ADDRS[(7 - i) * 8 +: 8], seed[15:8]);
            rd(BAD_RD[(7 - i) * 8 +: 8], 8'h00, 1'b0);
            if (i >= 4)
                issue(1'b1, BAD_WR[(7 - i) * 8 +: 8], seed[23:16]);
        end
        chk("settings kept", exp_set, settings);
        for (int k = 0; k < 3; k++)
        begin
            issue(1'b1, 8'h3f, 8'h00);
            chk("reset defaults", lpmr_pkg::WO_RESETS, settings);
            chk("init running", 1'b1, ai);
            repeat (110) @(negedge ref_clk);
            zq <= (k == 0) ? 3'b001 : (k == 1) ? 3'b100 : 3'b010;
            p0 = pulses;
            issue(1'b1, 8'h0a, 8'hff);
            issue(1'b1, 8'h0a, 8'h10);
            @(negedge ref_clk);
            chk("cal pulses", (k == 0) ? 2 : 0, pulses - p0);
            chk("trim", k != 0, trim);
            rd(8'h00, {3'h0, (k == 0) ? 2'h3 : k[1:0], 3'h0}, 1'b1);
        end
        repeat (10) @(negedge ref_clk);
        chk("notes left", 0, notes.size());
        final_report();
    end
endmodule : lpmr_mode_regs_tb

// ---- lpmr_pkg.sv ----
package lpmr_pkg;

    // Mode addresses
    localparam logic [7:0] MA_DEVICE_INFO   = 8'h00;
    localparam logic [7:0] MA_BURST_SETUP   = 8'h01;
    localparam logic [7:0] MA_LATENCY_SETUP = 8'h02;
    localparam logic [7:0] MA_IO_CONFIG_ONE = 8'h03;
    localparam logic [7:0] MA_REFRESH_STAT  = 8'h04;
    localparam logic [7:0] MA_MAKER_CODE    = 8'h05;
    localparam logic [7:0] MA_REVISION_ONE  = 8'h06;
    localparam logic [7:0] MA_REVISION_TWO  = 8'h07;
    localparam logic [7:0] MA_GEOMETRY      = 8'h08;
    localparam logic [7:0] MA_VENDOR_TEST   = 8'h09;
    localparam logic [7:0] MA_IMP_CAL_CMD   = 8'h0a;
    localparam logic [7:0] MA_BANK_MASK     = 8'h10;
    localparam logic [7:0] MA_SEGMENT_MASK  = 8'h11;
    localparam logic [7:0] MA_CAL_PATTERN_A = 8'h20;
    localparam logic [7:0] MA_CAL_PATTERN_B = 8'h28;
    localparam logic [7:0] MA_SOFT_RESET    = 8'h3f;

    // Write-only register slots, index order of the settings array
    localparam int         WO_COUNT = 7;
    localparam logic [WO_COUNT*8-1:0] WO_ADDRS = {
        MA_SEGMENT_MASK, MA_BANK_MASK, MA_IMP_CAL_CMD, MA_VENDOR_TEST,
        MA_IO_CONFIG_ONE, MA_LATENCY_SETUP, MA_BURST_SETUP};
    localparam logic [WO_COUNT*8-1:0] WO_RESETS = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h22};

    // Device information field positions
    localparam int DI_AUTO_INIT_BIT   = 0;
    localparam int DI_KIND_BIT        = 1;
    localparam int DI_INVALID_BIT     = 2;
    localparam int DI_SELFTEST_LSB    = 3;

    // Refresh status field positions
    localparam int RS_TEMP_FLAG_BIT   = 7;

    // Self-test result codes
    localparam logic [1:0] ST_NOT_RUN    = 2'h0;
    localparam logic [1:0] ST_TIED_VDD   = 2'h1;
    localparam logic [1:0] ST_SHORT_GND  = 2'h2;
    localparam logic [1:0] ST_RESISTOR   = 2'h3;

    // Calibration code that marks the initialization calibration
    localparam logic [7:0] IMP_CAL_INIT_CODE = 8'hff;

    // Auto-initialization longest duration
    localparam int CLK_PERIOD_NS   = 100;
    localparam int AUTO_INIT_MAX_NS = 10000;
    localparam int AUTO_INIT_CYC   = (AUTO_INIT_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                   : AUTO_INIT_MAX_NS / CLK_PERIOD_NS;
    localparam int BURST_BEATS_DEF = 4;

    // Command from the controller
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpmr_cmd_t;

    // Read answer toward the controller
    typedef struct packed {
        logic       valid;
        logic       strobe;
        logic       undefined;
        logic [7:0] data;
    } lpmr_rsp_t;

    // Stored write-only settings
    typedef struct packed {
        logic [7:0] segment_mask;
        logic [7:0] bank_mask;
        logic [7:0] imp_cal_code;
        logic [7:0] vendor_test;
        logic [7:0] io_config_one;
        logic [7:0] latency_setup;
        logic [7:0] burst_setup;
    } lpmr_settings_t;

endpackage : lpmr_pkg

// ---- lpmr_wreg.sv ----
`timescale 1ns/1ps
module lpmr_wreg #(
    parameter logic [7:0] ADDR      = 8'h00,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Clear from the reset command
    input  wire logic       clear,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Stored value and hit flag
    output logic      [7:0] value,
    output logic            hit
);

    logic [7:0] value_reg;

    // Address match
    assign hit   = (wr_addr == ADDR);
    assign value = value_reg;

    // Store on a matching write, default on reset or clear
    always_ff @(posedge ref_clk)
    begin
        if (rst || clear)
        begin
            value_reg <= RESET_VAL;
        end
        else if (wr_en && hit)
        begin
            value_reg <= wr_data;
        end
    end

endmodule : lpmr_wreg
